// ==== include/rtg_pkg.sv ====
// rtg_pkg: register map, field positions, reset values and types of the clock guard
package rtg_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACTL = 8'h04;
  localparam logic [7:0] OFS_TIME = 8'h08;
  localparam logic [7:0] OFS_DATE = 8'h0c;
  localparam logic [7:0] OFS_ATIME = 8'h10;
  localparam logic [7:0] OFS_ADATE = 8'h14;

  // clock_control_reg bits
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_WREN_BIT = 3;
  localparam int CTRL_ROLL_BIT = 2;
  localparam int CTRL_HALF_BIT = 1;
  localparam int CTRL_OE_BIT = 0;

  // alarm_control_reg bits and values
  localparam int ACTL_EN_BIT = 15;
  localparam int ACTL_SYNC_BIT = 12;
  localparam int ACTL_MASK_LSB = 8;
  localparam logic [15:0] ACTL_RST = 16'h0000;
  localparam logic [15:0] ACTL_WMASK = 16'hefff;
  localparam logic [3:0] ALARM_INTERVAL_MASK_HALF = 4'h0;

  // time and date layouts, all bcd
  localparam int SEC_LSB = 8;
  localparam int MIN_LSB = 16;
  localparam int HOUR_LSB = 24;
  localparam int WDAY_LSB = 0;
  localparam int DAY_LSB = 8;
  localparam int MON_LSB = 16;
  localparam int YEAR_LSB = 24;
  localparam logic [31:0] TIME_WMASK = 32'h3f7f7f00;
  localparam logic [31:0] DATE_WMASK = 32'hff1f3f07;
  localparam logic [31:0] TIME_RST = 32'h00000000;
  localparam logic [31:0] DATE_RST = 32'h00010106;

  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [2:0] WDAY_MAX = 3'h6;

  // secondary oscillator prescaler: 2^15 ticks per second
  localparam int PRESC_W = 15;
  localparam int ROLL_WIN_TICKS = 32;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_WAIT = 2'b10
  } rtg_bus_t;

endpackage

// ==== hw/rtg_sync3.sv ====
// rtg_sync3: three-flop pin synchroniser, a change counts when stages two and three agree
`timescale 1ns/1ps
module rtg_sync3
  import rtg_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] q;
  } rtg_sync_t;

  rtg_sync_t s;
  rtg_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.f1 = d;
    next_s.f2 = s.f1;
    next_s.f3 = s.f2;
    for (int i = 0; i < W; i++) begin
      if (s.f2[i] == s.f3[i]) begin
        next_s.q[i] = s.f3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= '{f1: INIT, f2: INIT, f3: INIT, q: INIT};
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule

// ==== hw/rtg_timekeep.sv ====
// rtg_timekeep: backup-domain prescaler, time and calendar counting chain
`timescale 1ns/1ps
module rtg_timekeep
  import rtg_pkg::*;
#(
  parameter int PRESC_WIDTH = PRESC_W,
  parameter int ROLL_WIN = ROLL_WIN_TICKS
) (
  input wire logic clk,
  input wire logic bat_rstn,
  input wire logic sosc_level,
  input wire logic on_wr,
  input wire logic on_wdata,
  input wire logic time_wr,
  input wire logic date_wr,
  input wire logic [31:0] wdata,
  output logic on,
  output logic half_sec,
  output logic roll_window,
  output logic roll_busy,
  output logic [31:0] cur_time,
  output logic [31:0] cur_date
);
  localparam logic [PRESC_WIDTH-1:0] PRE_MAX = '1;
  localparam logic [PRESC_WIDTH-1:0] ROLL_START = PRE_MAX - PRESC_WIDTH'(ROLL_WIN - 1);

  typedef struct packed {
    logic on;
    logic sosc_q;
    logic [PRESC_WIDTH-1:0] pre;
    logic [31:0] tm;
    logic [31:0] dt;
  } rtg_tk_t;

  rtg_tk_t s;
  rtg_tk_t next_s;
  logic tick, sec_c, min_c, hr_c, day_c, mon_c, yr_c, leap;
  logic [7:0] dlen;

  function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v >= hi) return lo;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return v + BCD_ONE;
  endfunction

  // bcd year 00..99 maps onto 2000..2099, where every multiple of four is leap
  assign leap = s.dt[YEAR_LSB+4] ? (s.dt[YEAR_LSB +: 4] == 4'h2 || s.dt[YEAR_LSB +: 4] == 4'h6)
              : (s.dt[YEAR_LSB +: 4] == 4'h0 || s.dt[YEAR_LSB +: 4] == 4'h4 ||
                 s.dt[YEAR_LSB +: 4] == 4'h8); // see RL11
  assign dlen = (s.dt[MON_LSB +: 8] == MON_FEB) ? (leap ? DAYS_29 : DAYS_28)
              : (s.dt[MON_LSB +: 8] == MON_APR || s.dt[MON_LSB +: 8] == MON_JUN ||
                 s.dt[MON_LSB +: 8] == MON_SEP || s.dt[MON_LSB +: 8] == MON_NOV) ? DAYS_30
              : DAYS_31;

  assign tick = s.on && sosc_level && !s.sosc_q;
  assign sec_c = tick && s.pre == PRE_MAX;
  assign min_c = sec_c && s.tm[SEC_LSB +: 8] == SEC_MAX;
  assign hr_c = min_c && s.tm[MIN_LSB +: 8] == MIN_MAX;
  assign day_c = hr_c && s.tm[HOUR_LSB +: 8] == HOUR_MAX;
  assign mon_c = day_c && s.dt[DAY_LSB +: 8] >= dlen;
  assign yr_c = mon_c && s.dt[MON_LSB +: 8] == MON_MAX;

  always_comb begin
    next_s = s;
    next_s.sosc_q = sosc_level;
    if (tick) begin
      next_s.pre = s.pre + 1'b1;
    end
    if (sec_c) next_s.tm[SEC_LSB +: 8] = bcd_next(s.tm[SEC_LSB +: 8], BCD_ZERO, SEC_MAX);
    if (min_c) next_s.tm[MIN_LSB +: 8] = bcd_next(s.tm[MIN_LSB +: 8], BCD_ZERO, MIN_MAX);
    if (hr_c) next_s.tm[HOUR_LSB +: 8] = bcd_next(s.tm[HOUR_LSB +: 8], BCD_ZERO, HOUR_MAX);
    if (day_c) begin
      next_s.dt[DAY_LSB +: 8] = bcd_next(s.dt[DAY_LSB +: 8], BCD_ONE, dlen);
      // weekday only advances, it is never derived from the date
      next_s.dt[WDAY_LSB +: 3] = (s.dt[WDAY_LSB +: 3] >= WDAY_MAX) ? 3'h0
                               : s.dt[WDAY_LSB +: 3] + 3'h1; // see RL10 see RL23
    end
    if (mon_c) next_s.dt[MON_LSB +: 8] = bcd_next(s.dt[MON_LSB +: 8], BCD_ONE, MON_MAX);
    if (yr_c) next_s.dt[YEAR_LSB +: 8] = bcd_next(s.dt[YEAR_LSB +: 8], BCD_ZERO, YEAR_MAX);
    if (on_wr) next_s.on = on_wdata;
    if (time_wr) begin
      next_s.tm = wdata & TIME_WMASK;
      next_s.pre = '0; // see RL4
    end
    if (date_wr) next_s.dt = wdata & DATE_WMASK;
  end

  // only the backup supply reset touches this state, never a device reset
  always_ff @(posedge clk or negedge bat_rstn) begin // see RL2 see RL3 see RL4
    if (!bat_rstn) begin
      s <= '{on: 1'b0, sosc_q: 1'b0, pre: '0, tm: TIME_RST, dt: DATE_RST};
    end else begin
      s <= next_s;
    end
  end

  assign on = s.on;
  assign half_sec = s.on && s.pre[PRESC_WIDTH-1]; // see RL6
  assign roll_window = s.on && s.pre >= ROLL_START; // see RL6
  assign roll_busy = s.on && sosc_level && s.pre == PRE_MAX;
  assign cur_time = s.tm;
  assign cur_date = s.dt;

  presc_only_a: assert property (@(posedge clk) disable iff (!bat_rstn) // see RL4
    $past(s.pre) != s.pre |-> s.pre == $past(s.pre) + 1'b1 || $past(time_wr))
    else $error("prescaler moved without tick or seconds write");
  wday_wrap_a: assert property (@(posedge clk) disable iff (!bat_rstn) // see RL23
    day_c && !date_wr |=> s.dt[WDAY_LSB +: 3] ==
      (($past(s.dt[WDAY_LSB +: 3]) == WDAY_MAX) ? 3'h0 : $past(s.dt[WDAY_LSB +: 3]) + 3'h1))
    else $error("weekday did not advance by one modulo seven");
  leap_day_a: assert property (@(posedge clk) disable iff (!bat_rstn) // see RL11
    day_c && !date_wr && leap && s.dt[MON_LSB +: 8] == MON_FEB &&
      s.dt[DAY_LSB +: 8] == DAYS_28 |=> s.dt[DAY_LSB +: 8] == DAYS_29)
    else $error("leap february skipped day 29");
  day_roll_c: cover property (@(posedge clk) disable iff (!bat_rstn) day_c);
endmodule

// ==== hw/rtg_guard.sv ====
// rtg_guard: clock and calendar register block with reset and update guards, AHB-Lite slave
//
// Behaviour
// RL1: device reset returns alarm control to reset
// RL2: enabled timekeeping survives device reset
// RL3: power-on reset leaves time and date alone
// RL4: prescaler cleared only by seconds field write
// RL5: watchdog reset acts as device reset
// RL6: enable low clears and holds sync flags
// RL7: clock pin driven only when enabled and on
// RL8: external reset pin leaves timekeeping running
// RL9: output enable low releases the clock pin
// RL10: weekday written by software, advanced per day
// RL11: leap years 2000 to 2099 detected automatically
// RL12: software writes only valid calendar dates
// RL13: disabled module allows free time writes
// RL14: enabled module: update only outside rollover window
// RL15: alarm write during busy rollover is dropped
// RL16: half-second alarm: update only without alarm sync
// RL17: time and date writes need write enable
// RL18: software masks interrupts during time updates
// RL19: alarm registers written only without alarm sync
// RL20: alarm control fields follow same sync restriction
// RL21: write enable clears freely, sets only unlocked
// RL22: software double-reads for a coherent value
// RL23: weekday counts zero to six and wraps
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module rtg_guard
  import rtg_pkg::*;
#(
  parameter int PRESC_WIDTH = PRESC_W,
  parameter int ROLL_WIN = ROLL_WIN_TICKS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic bat_rstn,
  input wire logic wdt_reset,
  input wire logic external_reset_pin_n,
  input wire logic sosc_in,
  input wire logic unlock_ok,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic clock_pin_o,
  output logic clock_pin_oe
);
  localparam int PIN_SOSC = 0;
  localparam int PIN_XRST = 1;

  typedef struct packed {
    rtg_bus_t state;
    logic hreadyout;
    logic [31:0] hrdata;
    logic dp_write;
    logic dp_word;
    logic dp_map;
    logic [7:0] dp_addr;
    logic oe;
    logic wren;
    logic [15:0] actl;
    logic [31:0] atime;
    logic [31:0] adate;
    logic pin_o;
    logic pin_oe;
  } rtg_main_t;

  localparam rtg_main_t MAIN_RST = '{state: BUS_IDLE, hreadyout: 1'b1, actl: ACTL_RST,
                                     default: '0};

  rtg_main_t s;
  rtg_main_t next_s;

  logic [1:0] pin_lvl;
  logic soft_rst;
  logic bus_take;
  logic dp_wr_go;
  logic wr_ctrl, wr_actl, wr_time, wr_date, wr_atime, wr_adate;
  logic tk_time_wr, tk_date_wr, on_wr;
  logic tk_on, tk_half_sec, tk_roll_window, tk_roll_busy;
  logic alarm_sync;
  logic [31:0] tk_time, tk_date;
  logic [31:0] ctrl_rd, actl_rd;

  // pins cross on the backup reset so a held external reset cannot stop the oscillator
  rtg_sync3 #(
    .W(2),
    .INIT(2'b10)
  ) u_pin_sync (
    .clk(hclk),
    .rstn(bat_rstn),
    .d({external_reset_pin_n, sosc_in}),
    .q(pin_lvl)
  );

  // watchdog and external pin reset the same state as hresetn, synchronously
  assign soft_rst = wdt_reset || !pin_lvl[PIN_XRST]; // see RL5

  assign bus_take = s.state == BUS_IDLE && hsel && htrans[1] && hready;
  // sub-word writes are ignored rather than merged
  assign dp_wr_go = s.state == BUS_WAIT && s.dp_write && s.dp_word && s.dp_map;
  assign wr_ctrl = dp_wr_go && s.dp_addr == OFS_CTRL;
  assign wr_actl = dp_wr_go && s.dp_addr == OFS_ACTL;
  assign wr_time = dp_wr_go && s.dp_addr == OFS_TIME;
  assign wr_date = dp_wr_go && s.dp_addr == OFS_DATE;
  assign wr_atime = dp_wr_go && s.dp_addr == OFS_ATIME;
  assign wr_adate = dp_wr_go && s.dp_addr == OFS_ADATE;

  assign on_wr = wr_ctrl;
  assign tk_time_wr = wr_time && s.wren; // see RL17
  assign tk_date_wr = wr_date && s.wren; // see RL17

  rtg_timekeep #(
    .PRESC_WIDTH(PRESC_WIDTH),
    .ROLL_WIN(ROLL_WIN)
  ) u_timekeep (
    .clk(hclk),
    .bat_rstn(bat_rstn),
    .sosc_level(pin_lvl[PIN_SOSC]), // see RL8
    .on_wr(on_wr),
    .on_wdata(hwdata[CTRL_ON_BIT]),
    .time_wr(tk_time_wr),
    .date_wr(tk_date_wr),
    .wdata(hwdata),
    .on(tk_on),
    .half_sec(tk_half_sec),
    .roll_window(tk_roll_window),
    .roll_busy(tk_roll_busy),
    .cur_time(tk_time),
    .cur_date(tk_date)
  );

  // flags are gated by the enable so they drop the instant it clears
  assign alarm_sync = tk_on && s.actl[ACTL_EN_BIT] && tk_roll_window; // see RL6

  always_comb begin
    ctrl_rd = 32'h0;
    ctrl_rd[CTRL_ON_BIT] = tk_on;
    ctrl_rd[CTRL_WREN_BIT] = s.wren;
    ctrl_rd[CTRL_ROLL_BIT] = tk_roll_window;
    ctrl_rd[CTRL_HALF_BIT] = tk_half_sec;
    ctrl_rd[CTRL_OE_BIT] = s.oe;
    actl_rd = {16'h0, s.actl};
    actl_rd[ACTL_SYNC_BIT] = alarm_sync;

    next_s = s;
    // seconds clock on the pin; enable masks the output enable
    next_s.pin_oe = tk_on && s.oe; // see RL7 see RL9
    next_s.pin_o = tk_on && s.oe && tk_half_sec; // see RL7
    unique case (s.state)
      BUS_IDLE: begin
        if (bus_take) begin
          next_s.state = BUS_WAIT;
          next_s.hreadyout = 1'b0;
          next_s.dp_write = hwrite;
          next_s.dp_word = hsize == HSIZE_WORD;
          next_s.dp_map = haddr[31:8] == 24'h0;
          next_s.dp_addr = haddr[7:0];
        end
      end
      BUS_WAIT: begin
        next_s.state = BUS_IDLE;
        next_s.hreadyout = 1'b1;
        next_s.hrdata = 32'h0;
        if (!s.dp_write && s.dp_map) begin
          case (s.dp_addr)
            OFS_CTRL: next_s.hrdata = ctrl_rd;
            OFS_ACTL: next_s.hrdata = actl_rd;
            OFS_TIME: next_s.hrdata = tk_time;
            OFS_DATE: next_s.hrdata = tk_date;
            OFS_ATIME: next_s.hrdata = s.atime;
            OFS_ADATE: next_s.hrdata = s.adate;
            default: next_s.hrdata = 32'h0;
          endcase
        end
        if (wr_ctrl) begin
          next_s.oe = hwdata[CTRL_OE_BIT];
          if (!hwdata[CTRL_WREN_BIT]) begin
            next_s.wren = 1'b0; // see RL21
          end else if (unlock_ok) begin
            next_s.wren = 1'b1; // see RL21
          end
        end
        if (wr_actl) begin
          next_s.actl = hwdata[15:0] & ACTL_WMASK;
        end
        // a write racing the rollover edge is lost with no trace
        if (wr_atime && !tk_roll_busy) begin // see RL15
          next_s.atime = hwdata & TIME_WMASK;
        end
        if (wr_adate && !tk_roll_busy) begin // see RL15
          next_s.adate = hwdata & DATE_WMASK;
        end
      end
      default: next_s = MAIN_RST;
    endcase
    if (soft_rst) begin
      next_s = MAIN_RST; // see RL1 see RL5
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= MAIN_RST; // see RL1
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
  assign clock_pin_o = s.pin_o;
  assign clock_pin_oe = s.pin_oe;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  alarm_reset_a: assert property (soft_rst |=> s.actl == ACTL_RST) // see RL1
    else $error("alarm control survived a device reset");

  wdt_same_a: assert property (wdt_reset |=> // see RL5
    s.actl == ACTL_RST && !s.wren && !s.oe && s.state == BUS_IDLE && hreadyout)
    else $error("watchdog reset differs from device reset");

  run_through_a: assert property (soft_rst && tk_on && !on_wr |=> tk_on) // see RL2
    else $error("timekeeping stopped by a device reset");

  xrst_run_a: assert property (!pin_lvl[PIN_XRST] && tk_on |=> tk_on) // see RL8
    else $error("external reset pin stopped the clock");

  flag_clear_a: assert property (!tk_on |-> // see RL6
    !ctrl_rd[CTRL_ROLL_BIT] && !ctrl_rd[CTRL_HALF_BIT] && !actl_rd[ACTL_SYNC_BIT])
    else $error("sync flag set while module disabled");

  pin_mask_a: assert property ($fell(tk_on) |=> !clock_pin_oe && !clock_pin_o) // see RL7
    else $error("clock pin still driven after disable");

  pin_release_a: assert property (!s.oe [*2] |-> !clock_pin_oe && !clock_pin_o) // see RL9
    else $error("clock pin not released with output disabled");

  wren_gate_a: assert property ((tk_time_wr || tk_date_wr) |-> s.wren) // see RL17
    else $error("time written without write enable");

  time_lock_a: assert property (wr_time && !s.wren && !tk_roll_busy && !tk_on // see RL17
    |=> tk_time == $past(tk_time))
    else $error("locked time register changed");

  wren_unlock_a: assert property (!s.wren ##1 s.wren |-> $past(unlock_ok)) // see RL21
    else $error("write enable set without unlock");

  wren_clear_a: assert property (wr_ctrl && !hwdata[CTRL_WREN_BIT] |=> !s.wren) // see RL21
    else $error("write enable clear refused");

  alarm_drop_a: assert property (wr_atime && tk_roll_busy && !soft_rst // see RL15
    |=> s.atime == $past(s.atime))
    else $error("alarm time written during rollover");

  bus_wait_a: assert property (bus_take && !soft_rst |=> !hreadyout ##1 (hreadyout && !hresp))
    else $error("bus answer not after one wait state");

  read_c: cover property (bus_take && !hwrite ##2 hreadyout);
  time_wr_c: cover property (tk_time_wr);
  alarm_drop_c: cover property (wr_atime && tk_roll_busy);
  wren_set_c: cover property (wr_ctrl && hwdata[CTRL_WREN_BIT] && unlock_ok);
endmodule

// ==== testbench/tb_top.sv ====
// tb_top: self-checking bench for the clock guard register block
`timescale 1ns/1ps
module tb_top
  import rtg_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic bat_rstn = 1'h0;
  logic wdt_reset = 1'h0;
  logic ext_rst_n = 1'h1;
  logic sosc_in = 1'h0;
  logic unlock_ok = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic clock_pin_o;
  logic clock_pin_oe;
  int num_errors = 0;
  int n_compared = 0;

  always #2.5 hclk = ~hclk;

  // short prescaler: 16 ticks per second, window of the last 2 ticks
  rtg_guard #(.PRESC_WIDTH(4), .ROLL_WIN(2)) dut (
    .hclk(hclk), .hresetn(hresetn), .bat_rstn(bat_rstn), .wdt_reset(wdt_reset),
    .external_reset_pin_n(ext_rst_n), .sosc_in(sosc_in), .unlock_ok(unlock_ok),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe)
  );

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ad(input logic [7:0] o);
    return {24'h000000, o};
  endfunction

  // one single transfer; the answer is waited for, never assumed
  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr_en;
    hsize <= HSIZE_WORD;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    check(r, exp);
    check({31'h0, hresp}, 32'h0);
  endtask

  // oscillator stands still between the ticks the bench asks for
  task automatic tick(input int n);
    for (int i = 0; i < n; i++) begin
      sosc_in <= 1'h1;
      repeat (4) @(posedge hclk);
      sosc_in <= 1'h0;
      repeat (4) @(posedge hclk);
    end
  endtask

  task automatic t_reset_values();
    rd_chk(ad(OFS_CTRL), 32'h0);
    rd_chk(ad(OFS_ACTL), {16'h0000, ACTL_RST});
    rd_chk(ad(OFS_TIME), TIME_RST);
    rd_chk(ad(OFS_DATE), DATE_RST);
    rd_chk(32'h00000100, 32'h0);
    rd_chk(32'h00000018, 32'h0);
  endtask

  task automatic t_write_lock();
    wr(ad(OFS_TIME), 32'h12345600);
    rd_chk(ad(OFS_TIME), TIME_RST);
    wr(ad(OFS_CTRL), 32'h00000008);
    rd_chk(ad(OFS_CTRL), 32'h0);
    unlock_ok <= 1'h1;
    wr(ad(OFS_CTRL), 32'h00000008);
    rd_chk(ad(OFS_CTRL), 32'h00000008);
    wr(ad(OFS_TIME), 32'h12345600);
    rd_chk(ad(OFS_TIME), 32'h12345600);
    wr(ad(OFS_CTRL), 32'h0);
    rd_chk(ad(OFS_CTRL), 32'h0);
  endtask

  task automatic t_day_rollover();
    logic [31:0] d_in [3];
    logic [31:0] d_exp [3];
    // leap 2004 with weekday wrap, non-leap 2003 with a weekday unrelated to the date, 2000
    d_in = '{32'h04022806, 32'h03022802, 32'h00022804};
    d_exp = '{32'h04022900, 32'h03030103, 32'h00022905};
    for (int i = 0; i < 3; i++) begin
      wr(ad(OFS_CTRL), 32'h00000008);
      wr(ad(OFS_TIME), 32'h23595900);
      wr(ad(OFS_DATE), d_in[i]);
      wr(ad(OFS_CTRL), 32'h00008008);
      tick(16);
      rd_chk(ad(OFS_DATE), d_exp[i]);
      rd_chk(ad(OFS_TIME), 32'h0);
      rd_chk(ad(OFS_TIME), 32'h0);
    end
    wr(ad(OFS_CTRL), 32'h00000008);
  endtask

  task automatic t_resets();
    logic [31:0] r;
    wr(ad(OFS_CTRL), 32'h00008008);
    wr(ad(OFS_TIME), 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(ad(OFS_ACTL), 32'h00008000);
      rd_chk(ad(OFS_ACTL), 32'h00008000);
      tick(10);
      // watchdog, device reset, external pin: each held while ticks go on
      if (k == 0) wdt_reset <= 1'h1;
      if (k == 1) hresetn <= 1'h0;
      if (k == 2) ext_rst_n <= 1'h0;
      tick(6);
      wdt_reset <= 1'h0;
      hresetn <= 1'h1;
      ext_rst_n <= 1'h1;
      repeat (10) @(posedge hclk);
      rd_chk(ad(OFS_ACTL), {16'h0000, ACTL_RST});
      bus(1'h0, ad(OFS_CTRL), 32'h0, r);
      check(r & 32'h00008000, 32'h00008000);
      rd_chk(ad(OFS_TIME), 32'h00000100 * (k + 1));
    end
  endtask

  task automatic t_window();
    wr(ad(OFS_CTRL), 32'h00008008);
    wr(ad(OFS_ATIME), 32'h12345600);
    // nothing interleaves check and update, so the flags stay low
    rd_chk(ad(OFS_CTRL), 32'h00008008);
    wr(ad(OFS_ACTL), 32'h00008000);
    rd_chk(ad(OFS_ACTL), 32'h00008000);
    wr(ad(OFS_TIME), 32'h0);
    tick(14);
    sosc_in <= 1'h1;
    repeat (8) @(posedge hclk);
    rd_chk(ad(OFS_CTRL), 32'h0000800e);
    wr(ad(OFS_ATIME), 32'h01020300);
    rd_chk(ad(OFS_ATIME), 32'h12345600);
    wr(ad(OFS_CTRL), 32'h00000008);
    rd_chk(ad(OFS_CTRL), 32'h00000008);
    wr(ad(OFS_CTRL), 32'h00008008);
    rd_chk(ad(OFS_CTRL), 32'h0000800e);
    sosc_in <= 1'h0;
    repeat (8) @(posedge hclk);
    wr(ad(OFS_ATIME), 32'h01020300);
    rd_chk(ad(OFS_ATIME), 32'h01020300);
  endtask

  task automatic t_pin();
    logic [31:0] v [3];
    logic e [3];
    v = '{32'h00008001, 32'h00000001, 32'h00008000};
    e = '{1'h1, 1'h0, 1'h0};
    for (int i = 0; i < 3; i++) begin
      wr(ad(OFS_CTRL), v[i]);
      repeat (2) @(posedge hclk);
      check({31'h0, clock_pin_oe}, {31'h0, e[i]});
      check({31'h0, clock_pin_o}, {31'h0, e[i]});
    end
  endtask

  initial begin
    repeat (100000) @(posedge hclk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    bat_rstn <= 1'h1;
    @(posedge hclk);
    t_reset_values();
    t_write_lock();
    t_day_rollover();
    t_resets();
    t_window();
    t_pin();
    end_sim();
  end
endmodule
